// file: rtl/ssb_pkg.sv
// constants, types and field layout for the system stack bounds and mapping block
`default_nettype none
package ssb_pkg;
   // register byte offsets
   localparam logic [7:0] SSB_OFF_SP = 8'h00;
   localparam logic [7:0] SSB_OFF_OVF = 8'h04;
   localparam logic [7:0] SSB_OFF_UNF = 8'h08;
   localparam logic [7:0] SSB_OFF_CFG = 8'h0C;
   localparam logic [7:0] SSB_OFF_STAT = 8'h10;
   localparam logic [7:0] SSB_OFF_PHYS = 8'h14;
   // reset values
   localparam logic [15:0] SSB_SP_RST = 16'hFC00;
   localparam logic [15:0] SSB_OVF_RST = 16'hFA00;
   localparam logic [15:0] SSB_UNF_RST = 16'hFC00;
   // virtual region and physical top
   localparam logic [15:0] SSB_REGION_BASE = 16'hF000;
   localparam logic [15:0] SSB_REGION_MASK = 16'h0FFE;
   localparam logic [15:0] SSB_PHYS_TOP = 16'hFBFE;
   localparam logic [15:0] SSB_WORD = 16'h0002;
   // stack size codes
   localparam logic [2:0] SSB_SZ_256 = 3'h0;
   localparam logic [2:0] SSB_SZ_128 = 3'h1;
   localparam logic [2:0] SSB_SZ_64 = 3'h2;
   localparam logic [2:0] SSB_SZ_32 = 3'h3;
   localparam logic [2:0] SSB_SZ_512 = 3'h4;
   localparam logic [2:0] SSB_SZ_LINEAR = 3'h7;
   localparam logic [2:0] SSB_SZ_RST = SSB_SZ_256;
   // significant pointer bit masks per size
   localparam logic [15:0] SSB_MASK_256 = 16'h01FF;
   localparam logic [15:0] SSB_MASK_128 = 16'h00FF;
   localparam logic [15:0] SSB_MASK_64 = 16'h007F;
   localparam logic [15:0] SSB_MASK_32 = 16'h003F;
   localparam logic [15:0] SSB_MASK_512 = 16'h03FF;
   localparam logic [15:0] SSB_MASK_LIN = 16'hFFFF;
   // field positions
   localparam int unsigned SSB_CFG_SZ_LSB = 0;
   localparam int unsigned SSB_STAT_OVF_BIT = 0;
   localparam int unsigned SSB_STAT_UNF_BIT = 1;
   localparam logic [3:0] SSB_IDX_REG_MAX = 4'h3;
   // core stack operations
   typedef enum logic [2:0] {
      SSB_OP_PUSH,
      SSB_OP_POP,
      SSB_OP_SUB,
      SSB_OP_ADD,
      SSB_OP_MOVE
   } ssb_op_t;
   // user stack addressing modes
   typedef enum logic [1:0] {
      SSB_UM_PREDEC,
      SSB_UM_POSTINC_IDX,
      SSB_UM_POSTINC
   } ssb_umode_t;
endpackage
`default_nettype wire

// file: rtl/ssb_stack_map.sv
// virtual to physical system stack address transformation
`default_nettype none
module ssb_stack_map
   import ssb_pkg::*;
(
   // virtual pointer and size
   input wire logic [15:0] sp,
   input wire logic [2:0] size_sel,
   // physical address
   output logic [15:0] phys
);
   logic [15:0] mask;

   always_comb begin
      case (size_sel)
         SSB_SZ_256: mask = SSB_MASK_256;
         SSB_SZ_128: mask = SSB_MASK_128;
         SSB_SZ_64: mask = SSB_MASK_64;
         SSB_SZ_32: mask = SSB_MASK_32;
         SSB_SZ_512: mask = SSB_MASK_512;
         SSB_SZ_LINEAR: mask = SSB_MASK_LIN;
         default: mask = SSB_MASK_256;
      endcase
      // low bits from pointer, upper bits from top; wraps in area
      phys = (sp & mask) | (SSB_PHYS_TOP & ~mask);
   end
endmodule
`default_nettype wire

// file: rtl/ssb_top.sv
// system stack pointer, bounds checking, mapping and apb register file
//
// Local design decisions: the APB register port and the register addresses.
`default_nettype none
module ssb_top
   import ssb_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // core stack operations
   input wire logic op_valid,
   input wire ssb_op_t op_code,
   input wire logic op_byte,
   input wire logic [15:0] op_data,
   // stack memory access
   output logic mem_valid,
   output logic mem_write,
   output logic [15:0] mem_addr,
   output logic [15:0] mem_wdata,
   // traps and pointer
   output logic trap_overflow,
   output logic trap_underflow,
   output logic [15:0] stack_pointer,
   // user stack addressing check
   input wire logic ustk_valid,
   input wire ssb_umode_t ustk_mode,
   input wire logic [3:0] ustk_reg,
   input wire logic ustk_is_move,
   output logic ustk_illegal
);
   logic [15:0] sp_q, sp_d, ovf_q, ovf_d, unf_q, unf_d;
   logic [2:0] size_q, size_d;
   logic sovf_q, sovf_d, sunf_q, sunf_d;
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d, pslverr_q, pslverr_d;
   logic mem_valid_q, mem_valid_d, mem_write_q, mem_write_d;
   logic [15:0] mem_addr_q, mem_addr_d, mem_wdata_q, mem_wdata_d;
   logic trap_ovf_q, trap_ovf_d, trap_unf_q, trap_unf_d;
   logic ustk_ill_q, ustk_ill_d;
   logic [15:0] sp_upd, sp_new, addr_src, phys_addr, phys_sp;
   logic chk_ovf, chk_unf, apb_setup, apb_wr;

   ssb_stack_map u_map_op (
      .sp(addr_src),
      .size_sel(size_q),
      .phys(phys_addr)
   );

   ssb_stack_map u_map_sp (
      .sp(sp_q),
      .size_sel(size_q),
      .phys(phys_sp)
   );

   assign apb_setup = psel && !penable;
   assign apb_wr = psel && penable && pready_q && pwrite && !pslverr_q;

   // stack operation datapath
   always_comb begin
      sp_upd = sp_q;
      chk_ovf = 1'b0;
      chk_unf = 1'b0;
      addr_src = sp_q;
      mem_valid_d = 1'b0;
      mem_write_d = 1'b0;
      mem_wdata_d = mem_wdata_q;
      if (op_valid) begin
         unique case (op_code)
            SSB_OP_PUSH: begin
               sp_upd = sp_q - SSB_WORD;
               chk_ovf = 1'b1;
               addr_src = sp_upd;
               mem_valid_d = 1'b1;
               mem_write_d = 1'b1;
               mem_wdata_d = op_byte ? {8'h00, op_data[7:0]} : op_data;
            end
            SSB_OP_POP: begin
               sp_upd = sp_q + SSB_WORD;
               chk_unf = 1'b1;
               mem_valid_d = 1'b1;
            end
            SSB_OP_SUB: begin
               sp_upd = sp_q - op_data;
               chk_ovf = 1'b1;
            end
            SSB_OP_ADD: begin
               sp_upd = sp_q + op_data;
               chk_unf = 1'b1;
            end
            SSB_OP_MOVE: begin
               sp_upd = op_data;
            end
            default: ;
         endcase
      end
      // keep pointer in region and even
      sp_new = SSB_REGION_BASE | (sp_upd & SSB_REGION_MASK);
      mem_addr_d = mem_valid_d ? phys_addr : mem_addr_q;
      trap_ovf_d = chk_ovf && (sp_new < ovf_q);
      trap_unf_d = chk_unf && (sp_new > unf_q);
   end

   // register file updates
   always_comb begin
      sp_d = sp_q;
      ovf_d = ovf_q;
      unf_d = unf_q;
      size_d = size_q;
      sovf_d = sovf_q;
      sunf_d = sunf_q;
      if (apb_wr) begin
         unique case (paddr)
            SSB_OFF_SP: sp_d = SSB_REGION_BASE | (pwdata[15:0] & SSB_REGION_MASK);
            SSB_OFF_OVF: ovf_d = SSB_REGION_BASE | (pwdata[15:0] & SSB_REGION_MASK);
            SSB_OFF_UNF: unf_d = SSB_REGION_BASE | (pwdata[15:0] & SSB_REGION_MASK);
            SSB_OFF_CFG: size_d = pwdata[SSB_CFG_SZ_LSB +: 3];
            SSB_OFF_STAT: begin
               if (pwdata[SSB_STAT_OVF_BIT]) sovf_d = 1'b0;
               if (pwdata[SSB_STAT_UNF_BIT]) sunf_d = 1'b0;
            end
            default: ;
         endcase
      end
      // core operation overrides a same-cycle software pointer write
      if (op_valid) sp_d = sp_new;
      // sticky flags: set wins over clear
      if (trap_ovf_d) sovf_d = 1'b1;
      if (trap_unf_d) sunf_d = 1'b1;
   end

   // apb answer, captured in the setup cycle
   always_comb begin
      prdata_d = prdata_q;
      pslverr_d = 1'b0;
      pready_d = 1'b0;
      if (apb_setup) begin
         pready_d = 1'b1;
         prdata_d = 32'h0000_0000;
         unique case (paddr)
            SSB_OFF_SP: prdata_d = {16'h0000, sp_q};
            SSB_OFF_OVF: prdata_d = {16'h0000, ovf_q};
            SSB_OFF_UNF: prdata_d = {16'h0000, unf_q};
            SSB_OFF_CFG: prdata_d = {29'h0000_0000, size_q};
            SSB_OFF_STAT: prdata_d = {30'h0000_0000, sunf_q, sovf_q};
            SSB_OFF_PHYS: prdata_d = {16'h0000, phys_sp};
            default: pslverr_d = 1'b1;
         endcase
         if (pwrite) prdata_d = 32'h0000_0000;
      end
   end

   // user stack mode check, no bounds logic here
   always_comb begin
      ustk_ill_d = 1'b0;
      if (ustk_valid) begin
         unique case (ustk_mode)
            SSB_UM_POSTINC_IDX: ustk_ill_d = (ustk_reg > SSB_IDX_REG_MAX);
            SSB_UM_PREDEC, SSB_UM_POSTINC: ustk_ill_d = !ustk_is_move;
            default: ustk_ill_d = 1'b1;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sp_q <= SSB_SP_RST;
         ovf_q <= SSB_OVF_RST;
         unf_q <= SSB_UNF_RST;
         size_q <= SSB_SZ_RST;
         sovf_q <= 1'b0;
         sunf_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         mem_valid_q <= 1'b0;
         mem_write_q <= 1'b0;
         mem_addr_q <= 16'h0000;
         mem_wdata_q <= 16'h0000;
         trap_ovf_q <= 1'b0;
         trap_unf_q <= 1'b0;
         ustk_ill_q <= 1'b0;
      end else begin
         sp_q <= sp_d;
         ovf_q <= ovf_d;
         unf_q <= unf_d;
         size_q <= size_d;
         sovf_q <= sovf_d;
         sunf_q <= sunf_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         mem_valid_q <= mem_valid_d;
         mem_write_q <= mem_write_d;
         mem_addr_q <= mem_addr_d;
         mem_wdata_q <= mem_wdata_d;
         trap_ovf_q <= trap_ovf_d;
         trap_unf_q <= trap_unf_d;
         ustk_ill_q <= ustk_ill_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign mem_valid = mem_valid_q;
   assign mem_write = mem_write_q;
   assign mem_addr = mem_addr_q;
   assign mem_wdata = mem_wdata_q;
   assign trap_overflow = trap_ovf_q;
   assign trap_underflow = trap_unf_q;
   assign stack_pointer = sp_q;
   assign ustk_illegal = ustk_ill_q;

   // checks
   AST_LSB_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
      !sp_q[0] && !ovf_q[0] && !unf_q[0])
      else $error("stack pointer or limit has odd value");

   AST_REGION: assert property (@(posedge pclk) disable iff (!presetn)
      sp_q[15:12] == SSB_REGION_BASE[15:12])
      else $error("stack pointer left virtual region");

   AST_PUSH_DEC: assert property (@(posedge pclk) disable iff (!presetn)
      (op_valid && op_code == SSB_OP_PUSH && sp_q[11:1] != 11'h000)
      |=> sp_q == $past(sp_q) - SSB_WORD && mem_write && mem_valid)
      else $error("push did not lower pointer by one word");

   AST_POP_INC: assert property (@(posedge pclk) disable iff (!presetn)
      (op_valid && op_code == SSB_OP_POP && sp_q[11:1] != 11'h7FF)
      |=> sp_q == $past(sp_q) + SSB_WORD && !mem_write && mem_valid)
      else $error("pop did not raise pointer by one word");

   AST_OVF_TRAP: assert property (@(posedge pclk) disable iff (!presetn)
      (op_valid && (op_code == SSB_OP_PUSH || op_code == SSB_OP_SUB))
      |=> trap_overflow == (sp_q < $past(ovf_q)) && !trap_underflow)
      else $error("overflow trap disagrees with limit");

   AST_UNF_TRAP: assert property (@(posedge pclk) disable iff (!presetn)
      (op_valid && (op_code == SSB_OP_POP || op_code == SSB_OP_ADD))
      |=> trap_underflow == (sp_q > $past(unf_q)) && !trap_overflow)
      else $error("underflow trap disagrees with limit");

   AST_MOVE_NOTRAP: assert property (@(posedge pclk) disable iff (!presetn)
      (op_valid && op_code == SSB_OP_MOVE) |=> !trap_overflow && !trap_underflow)
      else $error("move into pointer raised a trap");

   AST_BYTE_WIDEN: assert property (@(posedge pclk) disable iff (!presetn)
      (op_valid && op_code == SSB_OP_PUSH && op_byte)
      |=> mem_wdata == {8'h00, $past(op_data[7:0])})
      else $error("byte push not widened to word");

   AST_CIRC_256: assert property (@(posedge pclk) disable iff (!presetn)
      (mem_valid && $past(size_q) == SSB_SZ_256)
      |-> mem_addr[15:9] == SSB_PHYS_TOP[15:9])
      else $error("circular address outside 256-word area");

   AST_LINEAR: assert property (@(posedge pclk) disable iff (!presetn)
      (op_valid && op_code == SSB_OP_POP && size_q == SSB_SZ_LINEAR)
      |=> mem_addr == $past(sp_q))
      else $error("linear mode address was transformed");

   AST_USTK_IDX: assert property (@(posedge pclk) disable iff (!presetn)
      (ustk_valid && ustk_mode == SSB_UM_POSTINC_IDX)
      |=> ustk_illegal == ($past(ustk_reg) > SSB_IDX_REG_MAX))
      else $error("indexed post-increment register check wrong");

   AST_APB_ONE: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable) |=> pready ##1 !pready)
      else $error("apb answer not exactly one cycle");
endmodule
`default_nettype wire

// file: tb/ssb_tb.sv
// self-checking bench for the system stack bounds and mapping block
`default_nettype none
`define SSB_CHK(got, exp) begin checked++; if ((got) !== (exp)) begin mismatches++; \
   $display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end
module testbench
   import ssb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic op_valid = 1'b0;
   ssb_op_t op_code = SSB_OP_MOVE;
   logic op_byte = 1'b0;
   logic [15:0] op_data = 16'h0000;
   logic mem_valid;
   logic mem_write;
   logic [15:0] mem_addr;
   logic [15:0] mem_wdata;
   logic trap_overflow;
   logic trap_underflow;
   logic [15:0] stack_pointer;
   logic ustk_valid = 1'b0;
   ssb_umode_t ustk_mode = SSB_UM_PREDEC;
   logic [3:0] ustk_reg = 4'h0;
   logic ustk_is_move = 1'b0;
   logic ustk_illegal;
   int mismatches = 0;
   int checked = 0;
   logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
   logic [15:0] phys_exp [6] = '{16'hFA1A, 16'hFB1A, 16'hFB9A, 16'hFBDA, 16'hF81A, 16'hF41A};

   ssb_top ssb_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .op_valid(op_valid), .op_code(op_code), .op_byte(op_byte),
      .op_data(op_data), .mem_valid(mem_valid), .mem_write(mem_write), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .trap_overflow(trap_overflow), .trap_underflow(trap_underflow),
      .stack_pointer(stack_pointer), .ustk_valid(ustk_valid), .ustk_mode(ustk_mode),
      .ustk_reg(ustk_reg), .ustk_is_move(ustk_is_move), .ustk_illegal(ustk_illegal));

   always #25 pclk = ~pclk;

   task automatic stop_test;
      $display("mismatches %0d checked %0d", mismatches, checked);
      if (mismatches == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
         output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwrite <= 1'b0;
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic err;
      apb(1'b1, a, d, rd, err);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] rd;
      logic err;
      apb(1'b0, a, 32'h0000_0000, rd, err);
      `SSB_CHK(rd, e)
      `SSB_CHK(err, 1'b0)
   endtask

   // one core stack op, results checked in the cycle after it is taken
   task automatic core_op(input ssb_op_t c, input logic [15:0] d, input logic b,
         input logic [15:0] sp_e, input logic ov_e, input logic un_e);
      @(posedge pclk);
      op_valid <= 1'b1;
      op_code <= c;
      op_data <= d;
      op_byte <= b;
      @(posedge pclk);
      op_valid <= 1'b0;
      #1;
      `SSB_CHK(stack_pointer, sp_e)
      `SSB_CHK(trap_overflow, ov_e)
      `SSB_CHK(trap_underflow, un_e)
      `SSB_CHK(mem_valid, (c == SSB_OP_PUSH || c == SSB_OP_POP))
   endtask

   task automatic ustk(input ssb_umode_t m, input logic [3:0] r, input logic mv,
         input logic e);
      @(posedge pclk);
      ustk_valid <= 1'b1;
      ustk_mode <= m;
      ustk_reg <= r;
      ustk_is_move <= mv;
      @(posedge pclk);
      ustk_valid <= 1'b0;
      #1;
      `SSB_CHK(ustk_illegal, e)
   endtask

   initial begin
      repeat (20000) @(posedge pclk);
      mismatches++;
      stop_test();
   end

   initial begin
      logic [31:0] rd;
      logic err;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      #1;
      `SSB_CHK(stack_pointer, 16'hFC00)
      rd_chk(SSB_OFF_SP, 32'h0000_FC00);
      rd_chk(SSB_OFF_OVF, 32'h0000_FA00);
      rd_chk(SSB_OFF_UNF, 32'h0000_FC00);
      rd_chk(SSB_OFF_CFG, 32'h0000_0000);
      wr_reg(SSB_OFF_OVF, 32'h0000_FA0C);
      rd_chk(SSB_OFF_OVF, 32'h0000_FA0C);
      // push, byte push, pop
      core_op(SSB_OP_PUSH, 16'h1234, 1'b0, 16'hFBFE, 1'b0, 1'b0);
      `SSB_CHK(mem_addr, 16'hFBFE)
      `SSB_CHK(mem_wdata, 16'h1234)
      `SSB_CHK(mem_write, 1'b1)
      core_op(SSB_OP_PUSH, 16'hABCD, 1'b1, 16'hFBFC, 1'b0, 1'b0);
      `SSB_CHK(mem_wdata, 16'h00CD)
      core_op(SSB_OP_POP, 16'h0000, 1'b0, 16'hFBFE, 1'b0, 1'b0);
      `SSB_CHK(mem_addr, 16'hFBFC)
      `SSB_CHK(mem_write, 1'b0)
      // boundary traps
      wr_reg(SSB_OFF_OVF, 32'h0000_FBFC);
      core_op(SSB_OP_PUSH, 16'h0001, 1'b0, 16'hFBFC, 1'b0, 1'b0);
      core_op(SSB_OP_PUSH, 16'h0002, 1'b0, 16'hFBFA, 1'b1, 1'b0);
      core_op(SSB_OP_POP, 16'h0000, 1'b0, 16'hFBFC, 1'b0, 1'b0);
      wr_reg(SSB_OFF_UNF, 32'h0000_FBFC);
      core_op(SSB_OP_POP, 16'h0000, 1'b0, 16'hFBFE, 1'b0, 1'b1);
      rd_chk(SSB_OFF_STAT, 32'h0000_0003);
      wr_reg(SSB_OFF_STAT, 32'h0000_0003);
      rd_chk(SSB_OFF_STAT, 32'h0000_0000);
      core_op(SSB_OP_SUB, 16'h000A, 1'b0, 16'hFBF4, 1'b1, 1'b0);
      core_op(SSB_OP_ADD, 16'h000A, 1'b0, 16'hFBFE, 1'b0, 1'b1);
      core_op(SSB_OP_MOVE, 16'hF000, 1'b0, 16'hF000, 1'b0, 1'b0);
      core_op(SSB_OP_MOVE, 16'hFFFE, 1'b0, 16'hFFFE, 1'b0, 1'b0);
      // even pointer only
      wr_reg(SSB_OFF_SP, 32'h0000_FB11);
      rd_chk(SSB_OFF_SP, 32'h0000_FB10);
      `SSB_CHK(stack_pointer, 16'hFB10)
      core_op(SSB_OP_MOVE, 16'hFB13, 1'b0, 16'hFB12, 1'b0, 1'b0);
      // circular wrap of the 256 word area
      wr_reg(SSB_OFF_OVF, 32'h0000_F000);
      core_op(SSB_OP_MOVE, 16'hF802, 1'b0, 16'hF802, 1'b0, 1'b0);
      core_op(SSB_OP_PUSH, 16'h0011, 1'b0, 16'hF800, 1'b0, 1'b0);
      `SSB_CHK(mem_addr, 16'hFA00)
      core_op(SSB_OP_PUSH, 16'h0022, 1'b0, 16'hF7FE, 1'b0, 1'b0);
      `SSB_CHK(mem_addr, 16'hFBFE)
      // pointer stays inside the 4K region
      core_op(SSB_OP_MOVE, 16'hF000, 1'b0, 16'hF000, 1'b0, 1'b0);
      core_op(SSB_OP_SUB, 16'h0002, 1'b0, 16'hFFFE, 1'b0, 1'b0);
      wr_reg(SSB_OFF_OVF, 32'h0000_1235);
      rd_chk(SSB_OFF_OVF, 32'h0000_F234);
      // mapping for every size code, reserved codes never written
      core_op(SSB_OP_MOVE, 16'hF41A, 1'b0, 16'hF41A, 1'b0, 1'b0);
      for (int i = 0; i < 6; i++) begin
         wr_reg(SSB_OFF_CFG, {29'h0, codes[i]});
         rd_chk(SSB_OFF_PHYS, {16'h0000, phys_exp[i]});
      end
      wr_reg(SSB_OFF_OVF, 32'h0000_F000);
      core_op(SSB_OP_PUSH, 16'h0033, 1'b0, 16'hF418, 1'b0, 1'b0);
      `SSB_CHK(mem_addr, 16'hF418)
      core_op(SSB_OP_POP, 16'h0000, 1'b0, 16'hF41A, 1'b0, 1'b0);
      `SSB_CHK(mem_addr, 16'hF418)
      // unmapped address
      apb(1'b0, 8'h18, 32'h0000_0000, rd, err);
      `SSB_CHK(err, 1'b1)
      `SSB_CHK(rd, 32'h0000_0000)
      // user stack addressing modes
      ustk(SSB_UM_POSTINC_IDX, 4'h3, 1'b0, 1'b0);
      ustk(SSB_UM_POSTINC_IDX, 4'h4, 1'b1, 1'b1);
      ustk(SSB_UM_PREDEC, 4'hF, 1'b1, 1'b0);
      ustk(SSB_UM_PREDEC, 4'h2, 1'b0, 1'b1);
      ustk(SSB_UM_POSTINC, 4'h9, 1'b1, 1'b0);
      `SSB_CHK(trap_overflow, 1'b0)
      stop_test();
   end
endmodule
`default_nettype wire
